// file: hw/interrupt_enable_mask_logic.sv
// Interrupt enable mask register and request gating toward the CPU
// What this block does
// - Global enable bit 7 clear blocks every source regardless of own enables.
// - With global enable set, each source follows its own enable bit.
// - Bit 6 gates the ADC conversion-done flag.
// - Bit 5 gates the brown-out flag.
// - Bit 4 gates serial port 0 transmit or receive as one request.
// - Bit 3 gates the timer 1 overflow flag.
// - Bit 2 gates external interrupt 1 pin.
// - Bit 1 gates the timer 0 overflow flag.
// - Bit 0 gates external interrupt 0 pin.
// - Register at A8H on all pages, bit addressable, read/write, resets zero.
// - Brown-out flag set by hardware, cleared by software, needs both enables.
`timescale 1ns/1ps
`include "irq_enable_defs.svh"
module interrupt_enable_mask_logic
  import irq_enable_pkg::*;
(
  // Clock and reset
  input  wire logic         CLK_SYS_I,
  input  wire logic         SRST_I,
  // SFR byte access (page select ignored: visible on all pages)
  input  wire sfr_req_t     SFR_REQ_I,
  input  wire sfr_bit_req_t SFR_BIT_I,
  // Source flags; external pins are asynchronous
  input  wire irq_flags_t   FLAGS_I,
  // Read data and register view
  output logic [7:0]        SFR_RDATA_O,
  output logic              SFR_HIT_O,
  output logic [7:0]        INTERRUPT_ENABLE_MASK_O,
  // Requests to the CPU sequencer, indexed by irq_src_t
  output logic [6:0]        IRQ_REQ_O
);
  logic [7:0] interrupt_enable_mask;
  logic [7:0] next_mask;
  logic [1:0] ext0_sync;
  logic [1:0] ext1_sync;
  logic [6:0] src_raw;
  logic [6:0] next_req;
  logic       byte_hit;
  logic       bit_hit;

  assign byte_hit = SFR_REQ_I.addr == `IEM_SFR_ADDR;
  // Bit addresses A8H..AFH map onto bits 0..7
  assign bit_hit  = SFR_BIT_I.bit_addr[7:3]
                    == 5'(`IEM_BIT_ADDR_BASE >> 3);

  always_comb begin
    next_mask = interrupt_enable_mask;
    if (SFR_REQ_I.wr && byte_hit) begin
      next_mask = SFR_REQ_I.wdata;
    end else if (SFR_BIT_I.bit_wr && bit_hit) begin
      next_mask[SFR_BIT_I.bit_addr[2:0]] = SFR_BIT_I.bit_val;
    end
  end

  always_ff @(posedge CLK_SYS_I) begin
    if (SRST_I) begin
      interrupt_enable_mask <= `IEM_RESET;
    end else begin
      interrupt_enable_mask <= next_mask;
    end
  end

  // Two-stage synchronisers for the external pins
  always_ff @(posedge CLK_SYS_I) begin
    if (SRST_I) begin
      ext0_sync <= 2'h0;
      ext1_sync <= 2'h0;
    end else begin
      ext0_sync <= {ext0_sync[0], FLAGS_I.ext_irq0};
      ext1_sync <= {ext1_sync[0], FLAGS_I.ext_irq1};
    end
  end

  always_comb begin
    src_raw            = 7'h00;
    src_raw[SRC_EXT0]  = ext0_sync[1];
    src_raw[SRC_TMR0]  = FLAGS_I.timer0_overflow_flag;
    src_raw[SRC_EXT1]  = ext1_sync[1];
    src_raw[SRC_TMR1]  = FLAGS_I.timer1_overflow_flag;
    src_raw[SRC_SER0]  = FLAGS_I.serial_tx_flag
                       | FLAGS_I.serial_rx_flag;
    src_raw[SRC_BROWN] = FLAGS_I.brownout_flag;
    src_raw[SRC_ADC]   = FLAGS_I.adc_done_flag;
  end

  // Enable bits 0..6 line up with source index 0..6
  irq_request_gate #(
    .NSRC (7)
  ) u_gate (
    .global_en_i (interrupt_enable_mask[`IEM_BIT_GLOBAL]),
    .src_en_i    (interrupt_enable_mask[`IEM_BIT_ADC:`IEM_BIT_EXT0]),
    .src_raw_i   (src_raw),
    .req_o       (next_req)
  );

  always_ff @(posedge CLK_SYS_I) begin
    if (SRST_I) begin
      IRQ_REQ_O <= 7'h00;
    end else begin
      IRQ_REQ_O <= next_req;
    end
  end

  always_ff @(posedge CLK_SYS_I) begin
    if (SRST_I) begin
      SFR_RDATA_O             <= 8'h00;
      SFR_HIT_O               <= 1'b0;
      INTERRUPT_ENABLE_MASK_O <= `IEM_RESET;
    end else begin
      SFR_HIT_O               <= SFR_REQ_I.rd && byte_hit;
      SFR_RDATA_O             <= (SFR_REQ_I.rd && byte_hit)
                               ? interrupt_enable_mask : 8'h00;
      INTERRUPT_ENABLE_MASK_O <= next_mask;
    end
  end
endmodule

// file: hw/irq_enable_defs.svh
// Register address, bit positions and reset value of the interrupt enable mask
`ifndef IRQ_ENABLE_DEFS_SVH
`define IRQ_ENABLE_DEFS_SVH
`define IEM_SFR_ADDR   8'hA8
`define IEM_RESET      8'h00
`define IEM_BIT_GLOBAL 7
`define IEM_BIT_ADC    6
`define IEM_BIT_BROWN  5
`define IEM_BIT_SER0   4
`define IEM_BIT_TMR1   3
`define IEM_BIT_EXT1   2
`define IEM_BIT_TMR0   1
`define IEM_BIT_EXT0   0
`define IEM_BIT_ADDR_BASE 8'hA8
`endif

// file: hw/irq_enable_pkg.sv
// Types shared by the interrupt enable mask logic
package irq_enable_pkg;
  typedef struct packed {
    logic adc_done_flag;
    logic brownout_flag;
    logic serial_tx_flag;
    logic serial_rx_flag;
    logic timer1_overflow_flag;
    logic ext_irq1;
    logic timer0_overflow_flag;
    logic ext_irq0;
  } irq_flags_t;

  typedef struct packed {
    logic wr;
    logic rd;
    logic [7:0] addr;
    logic [7:0] wdata;
  } sfr_req_t;

  typedef struct packed {
    logic bit_wr;
    logic [7:0] bit_addr;
    logic bit_val;
  } sfr_bit_req_t;

  typedef enum {
    SRC_EXT0,
    SRC_TMR0,
    SRC_EXT1,
    SRC_TMR1,
    SRC_SER0,
    SRC_BROWN,
    SRC_ADC
  } irq_src_t;
endpackage

// file: hw/irq_request_gate.sv
// Per-source request gating by individual and global enables
`timescale 1ns/1ps
module irq_request_gate
  import irq_enable_pkg::*;
#(
  parameter int NSRC = 7
) (
  // Enables and raw source levels
  input  wire logic            global_en_i,
  input  wire logic [NSRC-1:0] src_en_i,
  input  wire logic [NSRC-1:0] src_raw_i,
  // Gated requests
  output logic      [NSRC-1:0] req_o
);
  genvar g;
  generate
    for (g = 0; g < NSRC; g++) begin : gen_gate
      // Flag AND own enable AND global enable
      assign req_o[g] = src_raw_i[g] & src_en_i[g] & global_en_i;
    end
  endgenerate
endmodule

// file: testbench/brownout_src_model.sv
// Brown-out flag source: set by detector, cleared by software
`timescale 1ns/1ps
module brownout_src_model (
  input  wire logic clk_i,
  input  wire logic set_i,
  input  wire logic clr_i,
  output logic      flag_o
);
  always_ff @(posedge clk_i) flag_o <= !clr_i && (set_i || flag_o);
endmodule

// file: testbench/iem_props.sv
// Port assertions for the interrupt enable mask logic
`timescale 1ns/1ps
module iem_props
  import irq_enable_pkg::*;
(
  input wire logic         CLK_SYS_I,
  input wire logic         SRST_I,
  input wire sfr_req_t     SFR_REQ_I,
  input wire sfr_bit_req_t SFR_BIT_I,
  input wire irq_flags_t   FLAGS_I,
  input wire logic [7:0]   SFR_RDATA_O,
  input wire logic         SFR_HIT_O,
  input wire logic [7:0]   INTERRUPT_ENABLE_MASK_O,
  input wire logic [6:0]   IRQ_REQ_O
);
  logic [7:0] m;
  logic       hit_rd;
  assign m = INTERRUPT_ENABLE_MASK_O;
  assign hit_rd = SFR_REQ_I.rd && SFR_REQ_I.addr == 8'hA8;
  default clocking @(posedge CLK_SYS_I); endclocking
  default disable iff (SRST_I);
  a_global_off: assert property (!$past(m[7]) |-> (IRQ_REQ_O & 7'h7F) == 0)
    else $error("request while globally off");
  a_ext0_gate: assert property
    (IRQ_REQ_O[0] == ($past(FLAGS_I[0], 3) & $past(m[0] & m[7])))
    else $error("ext0 request wrong");
  a_ext1_gate: assert property
    (IRQ_REQ_O[2] == ($past(FLAGS_I[2], 3) & $past(m[2] & m[7])))
    else $error("ext1 request wrong");
  a_adc_gate: assert property (IRQ_REQ_O[6] == $past(FLAGS_I[7] & m[6] & m[7]))
    else $error("adc request wrong");
  a_brown_gate: assert property (IRQ_REQ_O[5] == $past(FLAGS_I[6] & m[5] & m[7]))
    else $error("brownout request wrong");
  a_serial_gate: assert property
    (IRQ_REQ_O[4] == $past((FLAGS_I[5] | FLAGS_I[4]) & m[4] & m[7]))
    else $error("serial request wrong");
  a_tmr1_gate: assert property (IRQ_REQ_O[3] == $past(FLAGS_I[3] & m[3] & m[7]))
    else $error("timer1 request wrong");
  a_tmr0_gate: assert property (IRQ_REQ_O[1] == $past(FLAGS_I[1] & m[1] & m[7]))
    else $error("timer0 request wrong");
  a_read_hit: assert property (hit_rd |=> SFR_HIT_O && SFR_RDATA_O == $past(m))
    else $error("read of mask wrong");
  a_read_miss: assert property
    (SFR_REQ_I.rd && !hit_rd |=> !SFR_HIT_O && SFR_RDATA_O == 8'h00)
    else $error("foreign read answered");
  a_byte_write: assert property (SFR_REQ_I.wr && SFR_REQ_I.addr == 8'hA8
    |=> m == $past(SFR_REQ_I.wdata)) else $error("byte write lost");
  c_hit: cover property (SFR_HIT_O);
  c_brown: cover property (IRQ_REQ_O[5]);
  c_ext0: cover property ($rose(IRQ_REQ_O[0]));
endmodule
bind interrupt_enable_mask_logic iem_props i_props (.CLK_SYS_I(CLK_SYS_I),
  .SRST_I(SRST_I), .SFR_REQ_I(SFR_REQ_I), .SFR_BIT_I(SFR_BIT_I),
  .FLAGS_I(FLAGS_I), .SFR_RDATA_O(SFR_RDATA_O), .SFR_HIT_O(SFR_HIT_O),
  .INTERRUPT_ENABLE_MASK_O(INTERRUPT_ENABLE_MASK_O), .IRQ_REQ_O(IRQ_REQ_O));

// file: testbench/tb_top.sv
// Self-checking bench for the interrupt enable mask logic
`timescale 1ns/1ps
module tb_top;
  import irq_enable_pkg::*;
  logic         clk = 0, rst = 1, bo_set = 0, bo_clr = 1, bo, hit;
  sfr_req_t     rq = '0;
  sfr_bit_req_t bq = '0;
  logic [7:0]   fr = '0, m = '0, rdata, mask_o;
  logic [6:0]   req;
  irq_flags_t   fl;
  int           mismatches = 0, checks = 0, seed = 74522, cyc = 0;
  assign fl = {fr[7], bo, fr[5:0]};
  initial forever #2.5 clk = ~clk;
  always @(posedge clk) begin
    cyc++;
    if (cyc > 2000) begin
      mismatches++;
      finish_test();
    end
  end
  interrupt_enable_mask_logic i_dut (.CLK_SYS_I(clk), .SRST_I(rst),
    .SFR_REQ_I(rq), .SFR_BIT_I(bq), .FLAGS_I(fl), .SFR_RDATA_O(rdata),
    .SFR_HIT_O(hit), .INTERRUPT_ENABLE_MASK_O(mask_o), .IRQ_REQ_O(req));
  brownout_src_model i_bo (.clk_i(clk), .set_i(bo_set), .clr_i(bo_clr),
    .flag_o(bo));
  function automatic logic [7:0] exp(logic [7:0] k, irq_flags_t f);
    exp = {1'b0, f[7:6], f[5] | f[4], f[3:0]} & k & {8{k[7]}};
  endfunction
  task automatic step(int n);
    repeat (n) @(posedge clk);
    #1;
  endtask
  task automatic chk(logic [7:0] a, e);
    checks++;
    if (a !== e) begin
      mismatches++;
      $display("BAD %0t got %h want %h", $time, a, e);
    end
  endtask
  task automatic wr(logic [7:0] a, d);
    rq = '{1'b1, 1'b0, a, d};
    step(1);
    rq.wr = 0;
  endtask
  task automatic rd(logic [7:0] a, e);
    rq = '{1'b0, 1'b1, a, 8'h00};
    step(1);
    rq.rd = 0;
    chk({7'b0, hit}, {7'b0, a == 8'hA8});
    chk(rdata, a == 8'hA8 ? e : 8'h00);
  endtask
  task automatic bw(logic [7:0] a, logic v);
    bq = '{1'b1, a, v};
    step(1);
    bq.bit_wr = 0;
  endtask
  task automatic finish_test();
    if (mismatches == 0 && checks > 0) $display("Finished cleanly");
    else $display("Finished with errors");
    $finish;
  endtask
  initial begin
    step(12);
    rst = 0;
    chk(mask_o, 8'h00);
    rd(8'hA8, 8'h00);
    rd(8'hA9, 8'h00);
    repeat (200) begin
      m = $random(seed);
      fr = $random(seed) & 8'hFA;
      {bo_set, bo_clr} = $random(seed);
      wr(8'hA8, m);
      rd(8'hA8, m);
      chk({1'b0, req}, exp(m, fl));
    end
    wr(8'hA8, 8'h7F);
    bw(8'hAF, 1'b1);
    chk(mask_o, 8'hFF);
    bw(8'hAA, 1'b0);
    chk(mask_o, 8'hFB);
    wr(8'hA8, 8'h85);
    fr = 8'h05;
    step(4);
    chk({1'b0, req}, exp(8'h85, fl));
    wr(8'hA8, 8'h05);
    step(4);
    chk({1'b0, req}, 8'h00);
    rst = 1;
    step(2);
    rst = 0;
    chk(mask_o, 8'h00);
    chk({1'b0, req}, 8'h00);
    finish_test();
  end
endmodule
